// File: verilog/led_latch_pkg.sv
/*
 * Shared constants and carrier types for the serial LED latch driver.
 * Assumes a system clock at 10 MHz and a separate serial shift clock.
 */
package led_latch_pkg;

    localparam int WORD_BITS = 8;
    localparam logic [7:0] SHIFT_RESET = 8'h00;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic SERIAL_OUT_RESET = 1'h0;
    localparam int SYNC_STAGES = 2;

    // Serial link pins as seen by the device
    typedef struct packed {
        logic data;
        logic latch_load;
        logic blank_n;
    } serial_in_t;

    // Open-drain sink pins: sinking when enabled, output level always low
    typedef struct packed {
        logic [7:0] sink_oe;
        logic [7:0] sink_out;
    } led_drive_t;

endpackage : led_latch_pkg

// File: verilog/led_shift_latch_driver.sv
/*
 * Eight-output LED sink driver: serial shift register on the link clock,
 * output latch and sink drivers in the system clock domain.
 * Assumes rst is held by the surrounding logic at power-up, synchronous to
 * both clocks, and that the host drives data/latch_load with setup before
 * the rising edge of shift_clk.
 */
module led_shift_latch_driver #(
    parameter int WIDTH = led_latch_pkg::WORD_BITS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic shift_clk,
    input wire logic serial_data,
    input wire logic latch_load,
    input wire logic blank_n,
    output logic serial_out,
    output logic [WIDTH-1:0] led_sink_out,
    output logic [WIDTH-1:0] led_sink_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Link domain: shift register on shift_clk

    // Eight stages only: the last stage feeds serial_out directly, so a bit
    // taken on one rising edge reaches the pin on the eighth edge counted
    // from that one, and a cascaded device sees no extra delay stage
    logic [WIDTH-1:0] shift_reg;
    logic [WIDTH-1:0] shift_next;
    logic rst_link_meta_reg;
    logic rst_link_reg;

    // Reset resynchronised so the link never samples rst mid-edge
    always_ff @(posedge shift_clk)
    begin
        rst_link_meta_reg <= rst;
        rst_link_reg <= rst_link_meta_reg;
    end

    // Stage 0 takes the newest bit, so the first bit sent ends in the top stage
    assign shift_next = {shift_reg[WIDTH-2:0], serial_data};

    always_ff @(posedge shift_clk)
    begin
        if (rst_link_reg)
            shift_reg <= '0;
        else
            shift_reg <= shift_next;
    end

    // Word as host sees it: first stage is bit 0
    logic [WIDTH-1:0] word_link;
    assign word_link = shift_reg;

    // Forced low straight from rst: the link flops clear only once the link
    // clock has run, and the pin must read low before that happens
    assign serial_out = rst ? led_latch_pkg::SERIAL_OUT_RESET : shift_reg[WIDTH-1];

    ////////////////////////////////////////////////////////////////////////
    // Crossing: word sampled through two flops; a change is only trusted
    // once two consecutive samples agree, which avoids a torn word

    logic [WIDTH-1:0] word_meta_reg;
    logic [WIDTH-1:0] word_sync_reg;
    logic [WIDTH-1:0] word_prev_reg;
    logic load_meta_reg;
    logic load_sync_reg;
    logic blank_meta_reg;
    logic blank_n_sync_reg;
    wire word_stable = (word_sync_reg == word_prev_reg);

    always_ff @(posedge clk)
    begin
        word_meta_reg <= word_link;
        word_sync_reg <= word_meta_reg;
        word_prev_reg <= word_sync_reg;
        load_meta_reg <= latch_load;
        load_sync_reg <= load_meta_reg;
        blank_meta_reg <= blank_n;
        blank_n_sync_reg <= blank_meta_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // Output latch: transparent while load high and the word stable, holds otherwise

    logic [WIDTH-1:0] latch_reg;
    logic [WIDTH-1:0] latch_next;
    wire latch_follow = load_sync_reg && word_stable;

    // Falling edge needs no action: last followed value simply stays
    assign latch_next = latch_follow ? word_sync_reg : latch_reg;

    always_ff @(posedge clk)
    begin
        if (rst)
            latch_reg <= led_latch_pkg::LATCH_RESET;
        else
            latch_reg <= latch_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sink drivers: open-drain, pin level always low, enable means sinking

    logic [WIDTH-1:0] oe_reg;
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_sink
            always_ff @(posedge clk)
            begin
                if (rst)
                    oe_reg[i] <= 1'b0;
                else
                    oe_reg[i] <= ~blank_n_sync_reg & latch_reg[i];
            end
        end
    endgenerate

    assign led_sink_out = '0;
    assign led_sink_oe = oe_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_blank_release: assert property (@(posedge clk) disable iff (rst)
        blank_n_sync_reg |=> (led_sink_oe == '0))
        else $error("sinks active while blanked");

    a_sink_follow: assert property (@(posedge clk) disable iff (rst)
        !blank_n_sync_reg |=> (led_sink_oe == $past(latch_reg)))
        else $error("sink does not follow latch");

    a_latch_hold: assert property (@(posedge clk) disable iff (rst)
        !load_sync_reg |=> $stable(latch_reg))
        else $error("latch changed while load low");

    a_latch_pass: assert property (@(posedge clk) disable iff (rst)
        (load_sync_reg && word_stable) |=> (latch_reg == $past(word_sync_reg)))
        else $error("latch not transparent");

    a_blank_keeps: assert property (@(posedge clk) disable iff (rst)
        (blank_n_sync_reg && !load_sync_reg) |=> $stable(latch_reg))
        else $error("blanking altered latch");

    a_sink_low: assert property (@(posedge clk) led_sink_out == '0)
        else $error("sink pin driven high");

    a_reset_clear: assert property (@(posedge clk)
        rst |=> (latch_reg == '0 && led_sink_oe == '0))
        else $error("reset did not clear");

    a_shift_in: assert property (@(posedge shift_clk) disable iff (rst_link_reg)
        1'b1 |=> (shift_reg[0] == $past(serial_data)))
        else $error("data not shifted in");

    a_shift_eight: assert property (@(posedge shift_clk) disable iff (rst_link_reg)
        1'b1 |=> ##7 (serial_out == $past(serial_data, 8)))
        else $error("serial out not eight edges late");

    // Each edge moves every stage up by one, oldest bit towards serial_out
    a_word_shift: assert property (@(posedge shift_clk) disable iff (rst_link_reg)
        1'b1 |=> (shift_reg[WIDTH-1:1] == $past(shift_reg[WIDTH-2:0])))
        else $error("shift stages not moved up by one");

    // Link side clears on the edge after its own reset flop is set
    a_link_reset: assert property (@(posedge shift_clk)
        rst_link_reg |=> (shift_reg == '0))
        else $error("shift register not cleared");

    // Checked on the system clock: the pin must be low whatever the link does
    a_serial_reset: assert property (@(posedge clk)
        rst |-> (serial_out == 1'b0))
        else $error("serial out not low in reset");

    // No sink may pull unless its own latch bit asked for it
    a_sink_latched: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> ((led_sink_oe & ~$past(latch_reg)) == '0))
        else $error("sink on without its latch bit");

    // The cycle after load drops must already hold the captured word
    a_latch_capture: assert property (@(posedge clk) disable iff (rst)
        $fell(load_sync_reg) |=> $stable(latch_reg))
        else $error("latch moved after load fell");

    ////////////////////////////////////////////////////////////////////////
    // Coverage of the main scenarios

    c_latch_load: cover property (@(posedge clk) disable iff (rst)
        load_sync_reg ##1 !load_sync_reg);
    c_sink_on: cover property (@(posedge clk) disable iff (rst)
        led_sink_oe == 8'hFF);
    c_blank_toggle: cover property (@(posedge clk) disable iff (rst)
        !blank_n_sync_reg ##1 blank_n_sync_reg);
    c_serial_pulse: cover property (@(posedge shift_clk) disable iff (rst_link_reg)
        serial_out ##1 !serial_out);
    c_latch_follow: cover property (@(posedge clk) disable iff (rst)
        latch_follow ##1 !load_sync_reg);

endmodule : led_shift_latch_driver

// File: sim/led_host_model.sv
/* Host side of the serial LED link: shift clock, data, load and blank.
   Assumes the bench calls shift_bits; the link clock stands still between frames. */
module led_host_model (
    output logic shift_clk = 1'h0,
    output logic serial_data = 1'h0,
    output logic latch_load = 1'h0,
    output logic blank_n = 1'h1
);
    timeunit 1ns;
    timeprecision 100ps;
    ////////////////////////////////////////////////////////////////////////////
    // MSB first at a 6 ns period; data is set half a period before the rise
    task automatic shift_bits(input logic [7:0] w, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_data = w[i];
            #3 shift_clk = 1'h1;
            #3 shift_clk = 1'h0;
        end
        // Released line shows no stale bit
        serial_data = ~serial_data;
    endtask : shift_bits
endmodule : led_host_model

// File: sim/tb_top.sv
/* Self-checking bench for the LED latch driver.
   Assumes the host model in led_host_model.sv drives every link input. */
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic shift_clk, serial_data, latch_load, blank_n, serial_out;
    logic [7:0] led_sink_out, led_sink_oe;
    int n_errors = 0;
    int n_tests = 0;
    initial forever #50 clk = ~clk;
    led_host_model u_host (.shift_clk(shift_clk), .serial_data(serial_data),
        .latch_load(latch_load), .blank_n(blank_n));
    led_shift_latch_driver #(.WIDTH(8)) u_dut (.clk(clk), .rst(rst), .shift_clk(shift_clk),
        .serial_data(serial_data), .latch_load(latch_load), .blank_n(blank_n),
        .serial_out(serial_out), .led_sink_out(led_sink_out), .led_sink_oe(led_sink_oe));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s exp %h got %h", name, exp, got);
        end
    endtask : check
    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : ticks
    // Bounded wait; the sync path has a few cycles of slack
    task automatic wait_oe(input logic [7:0] exp);
        for (int i = 0; i < 12 && led_sink_oe !== exp; i++)
            ticks(1);
        check("led_sink_oe", led_sink_oe, exp);
        if (led_sink_oe !== exp)
            print_verdict();
    endtask : wait_oe
    // Load stays high while shifting, so the latch must follow
    task automatic load_word(input logic [7:0] w);
        u_host.latch_load = 1'h1;
        u_host.shift_bits(w, 8);
        ticks(8);
        u_host.latch_load = 1'h0;
    endtask : load_word
    task automatic print_verdict();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        u_host.shift_bits(8'hFF, 4);
        ticks(10);
        rst = 1'h0;
        ticks(1);
        check("serial_out", {7'h00, serial_out}, 8'h00);
        check("led_sink_oe", led_sink_oe, 8'h00);
        u_host.shift_bits(8'h00, 3);
        $display("done reset");
        load_word(8'hA5);
        u_host.blank_n = 1'h0;
        wait_oe(8'hA5);
        check("led_sink_out", led_sink_out, 8'h00);
        $display("done latch");
        for (int i = 7; i >= 0; i--)
        begin
            check("serial_out", {7'h00, serial_out}, {7'h00, 1'(8'hA5 >> i)});
            u_host.shift_bits(8'h3C >> i, 1);
        end
        ticks(10);
        check("led_sink_oe", led_sink_oe, 8'hA5);
        $display("done hold");
        u_host.blank_n = 1'h1;
        wait_oe(8'h00);
        u_host.blank_n = 1'h0;
        wait_oe(8'hA5);
        u_host.blank_n = 1'h1;
        load_word(8'h3C);
        u_host.blank_n = 1'h0;
        wait_oe(8'h3C);
        $display("done blank");
        print_verdict();
    end
endmodule : tb_top
